/* File: logic/mbd_pkg.sv */
// package: timing constants for the memory bus dma cycle port
// Summary of operation
// - channel cycle runs grant rise to inhibit end
// - processor drives read and write timing lines
// - same timing for core and read-only modules
// - address stable from 120 ns to inhibit end
// - address released within 180 ns of inhibit end
// - write-select stable 220 to 500 ns after grant
// - read readout pulse 30-100 ns at 400-470 ns
// - channel captures readout and drives it back
// - write data stable 300 ns to inhibit end
// - read data returned before inhibit start, held
// - data lines released within 180 ns of end
// - parity data bit driven only by processor
// - start pulse sets request, request drives line
// - chain captured if requesting, else forwarded
// - chain delay through channel at most 48 ns
// - capture clears request and sets select
// - inhibit end clears select, channel disconnects
// - top channel ties chain-in active
// - reset clears request and select flip-flops
// - request sampled each cycle, 240 ns grant
// - request dropped within 500 ns of grant
// - processor yields cycle to any requesting channel
`default_nettype none

package mbd_pkg;

  // ----------------------------------------
  // bus and cycle counter widths
  // ----------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int TW     = 6;

  // ----------------------------------------
  // timing in nanoseconds
  // ----------------------------------------
  localparam int CLK_NS         = 20;
  localparam int CYCLE_NS       = 900;
  localparam int GRANT_W_NS     = 240;
  localparam int ER_START_NS    = 20;
  localparam int ER_END_NS      = 180;
  localparam int LR_START_NS    = 80;
  localparam int LR_END_NS      = 260;
  localparam int SAMPLE_NS      = 400;
  localparam int READOUT_AT_NS  = 420;
  localparam int READOUT_W_NS   = 60;
  localparam int INH_START_NS   = 540;
  localparam int INH_END_NS     = 840;
  localparam int RD_OPEN_NS     = 400;
  localparam int RD_CLOSE_NS    = 480;

  // ----------------------------------------
  // derived cycle positions (all exact multiples of the clock)
  // ----------------------------------------
  localparam logic [TW-1:0] T_LAST     = TW'(CYCLE_NS / CLK_NS - 1);
  localparam logic [TW-1:0] T_GRANT    = TW'(GRANT_W_NS / CLK_NS);
  localparam logic [TW-1:0] T_ER_S     = TW'(ER_START_NS / CLK_NS);
  localparam logic [TW-1:0] T_ER_E     = TW'(ER_END_NS / CLK_NS);
  localparam logic [TW-1:0] T_LR_S     = TW'(LR_START_NS / CLK_NS);
  localparam logic [TW-1:0] T_LR_E     = TW'(LR_END_NS / CLK_NS);
  localparam logic [TW-1:0] T_SAMPLE   = TW'(SAMPLE_NS / CLK_NS);
  localparam logic [TW-1:0] T_RD       = TW'(READOUT_AT_NS / CLK_NS);
  localparam logic [TW-1:0] T_RD_E     = TW'((READOUT_AT_NS + READOUT_W_NS) / CLK_NS);
  localparam logic [TW-1:0] T_INH_S    = TW'(INH_START_NS / CLK_NS);
  localparam logic [TW-1:0] T_INH_E    = TW'(INH_END_NS / CLK_NS);
  localparam logic [TW-1:0] T_STORE    = TW'(INH_END_NS / CLK_NS - 1);
  localparam logic [TW-1:0] T_RD_OPEN  = TW'(RD_OPEN_NS / CLK_NS);
  localparam logic [TW-1:0] T_RD_CLOSE = TW'(RD_CLOSE_NS / CLK_NS);
  localparam logic [TW-1:0] T_RD_DRIVE = TW'(RD_CLOSE_NS / CLK_NS + 1);
  localparam logic [TW-1:0] T_SAT      = TW'(63);

endpackage

`default_nettype wire

/* File: logic/mbd_bus_if.sv */
// interface: memory bus between processor timing end and one dma channel
`default_nettype none

interface mbd_bus_if;

  // ----------------------------------------
  // processor driven
  // ----------------------------------------
  logic                        grant_pulse;
  logic                        inhibit_timing;
  logic                        early_read_timing;
  logic                        late_read_timing;
  logic [mbd_pkg::DATA_W:0]    strobed_readout_lines;
  logic                        par_o;
  logic                        par_oe;

  // ----------------------------------------
  // channel driven, open collector
  // ----------------------------------------
  logic [mbd_pkg::ADDR_W-1:0]  addr_o;
  logic                        addr_oe;
  logic                        wsel_o;
  logic                        wsel_oe;
  logic [mbd_pkg::DATA_W-1:0]  data_o;
  logic                        data_oe;
  logic                        req_oe;

  // ----------------------------------------
  // resolved wire levels (true = active)
  // ----------------------------------------
  logic [mbd_pkg::ADDR_W-1:0]  mem_addr_lines;
  logic                        write_select;
  logic [mbd_pkg::DATA_W:0]    mem_data_lines;
  logic                        mem_request_line;

  assign mem_addr_lines   = addr_oe ? addr_o : '0;
  assign write_select     = wsel_oe & wsel_o;
  assign mem_data_lines   = {par_oe & par_o, data_oe ? data_o : 8'h00};
  assign mem_request_line = req_oe;

  modport device (
    output grant_pulse, inhibit_timing, early_read_timing, late_read_timing,
    output strobed_readout_lines, par_o, par_oe,
    input  mem_addr_lines, write_select, mem_data_lines, mem_request_line
  );

  modport channel (
    input  grant_pulse, inhibit_timing, early_read_timing, late_read_timing,
    input  strobed_readout_lines,
    output addr_o, addr_oe, wsel_o, wsel_oe, data_o, data_oe, req_oe
  );

endinterface

`default_nettype wire

/* File: logic/mbd_device.sv */
// module: processor end, memory timing generator, arbiter and storage array
`default_nettype none

module mbd_device (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // processor own memory port
  input  wire logic                       cpu_req,
  input  wire logic [mbd_pkg::ADDR_W-1:0] cpu_addr,
  input  wire logic                       cpu_we,
  input  wire logic [mbd_pkg::DATA_W-1:0] cpu_wdata,
  output logic                            cpu_done,
  output logic [mbd_pkg::DATA_W-1:0]      cpu_rdata,
  // memory bus
  mbd_bus_if.device                       bus
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {MBD_IDLE, MBD_DMA, MBD_CPU} mbd_kind_t;

  typedef struct packed {
    mbd_kind_t                  kind;
    logic [mbd_pkg::TW-1:0]     t;
    logic                       grant;
    logic                       inh;
    logic                       er;
    logic                       lr;
    logic                       par;
    logic                       par_oe;
    logic [mbd_pkg::DATA_W:0]   readout;
    logic [mbd_pkg::ADDR_W-1:0] addr;
    logic                       we;
    logic [mbd_pkg::DATA_W-1:0] wdata;
    logic [mbd_pkg::DATA_W-1:0] rdata;
    logic                       done;
    logic                       req_seen;
  } mbd_dev_t;

  mbd_dev_t                   s;
  mbd_dev_t                   next_s;
  logic                       active;
  logic [mbd_pkg::DATA_W:0]   word;
  logic [mbd_pkg::DATA_W-1:0] wbyte;

  // parity lives in bit 8 of every stored word
  logic [mbd_pkg::DATA_W:0]   mem [2**mbd_pkg::ADDR_W];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s          = s;
    next_s.done     = 1'b0;
    next_s.req_seen = bus.mem_request_line;
    if (s.kind == MBD_IDLE || s.t == mbd_pkg::T_LAST) begin
      next_s.t    = '0;
      next_s.done = (s.kind == MBD_CPU);
      // request must stand two samples, so grant never follows it within 30 ns
      if (bus.mem_request_line && s.req_seen) begin
        next_s.kind = MBD_DMA;
      end else if (bus.mem_request_line) begin
        next_s.kind = MBD_IDLE;
      end else if (cpu_req) begin
        next_s.kind  = MBD_CPU;
        next_s.addr  = cpu_addr;
        next_s.we    = cpu_we;
        next_s.wdata = cpu_wdata;
      end else begin
        next_s.kind = MBD_IDLE;
      end
    end else begin
      next_s.t = s.t + 6'h01;
    end
    // address and direction taken well inside their stable windows
    if (s.kind == MBD_DMA && s.t == mbd_pkg::T_SAMPLE) begin
      next_s.addr = bus.mem_addr_lines;
      next_s.we   = bus.write_select;
    end
    active       = (next_s.kind != MBD_IDLE);
    next_s.grant = (next_s.kind == MBD_DMA) && (next_s.t < mbd_pkg::T_GRANT);
    next_s.er    = active && next_s.t >= mbd_pkg::T_ER_S && next_s.t < mbd_pkg::T_ER_E;
    next_s.lr    = active && next_s.t >= mbd_pkg::T_LR_S && next_s.t < mbd_pkg::T_LR_E;
    next_s.inh   = active && next_s.t >= mbd_pkg::T_INH_S && next_s.t < mbd_pkg::T_INH_E;
    word         = mem[next_s.addr];
    if (active && !next_s.we && next_s.t >= mbd_pkg::T_RD && next_s.t < mbd_pkg::T_RD_E) begin
      next_s.readout = word;
    end else begin
      next_s.readout = '0;
    end
    if (next_s.kind == MBD_CPU && next_s.t == mbd_pkg::T_RD) begin
      next_s.rdata = word[mbd_pkg::DATA_W-1:0];
    end
    // core reads are destructive: channel reads restore what the channel hands back, processor reads the byte captured at T_RD
    if (s.kind == MBD_DMA) begin
      wbyte = bus.mem_data_lines[mbd_pkg::DATA_W-1:0];
    end else begin
      wbyte = s.we ? s.wdata : s.rdata;
    end
    next_s.par_oe = next_s.inh;
    next_s.par    = ^wbyte;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (s.kind != MBD_IDLE && s.t == mbd_pkg::T_STORE) begin
      mem[s.addr] <= {^wbyte, wbyte};
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus.grant_pulse           = s.grant;
  assign bus.inhibit_timing        = s.inh;
  assign bus.early_read_timing     = s.er;
  assign bus.late_read_timing      = s.lr;
  assign bus.strobed_readout_lines = s.readout;
  assign bus.par_o                 = s.par;
  assign bus.par_oe                = s.par_oe;
  assign cpu_done                  = s.done;
  assign cpu_rdata                 = s.rdata;

endmodule

`default_nettype wire

/* File: logic/mbd_channel.sv */
// module: dma channel end, request, chain capture and bus drive
`default_nettype none

module mbd_channel (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // user service port
  input  wire logic                       svc_start,
  input  wire logic [mbd_pkg::ADDR_W-1:0] svc_addr,
  input  wire logic                       svc_we,
  input  wire logic [mbd_pkg::DATA_W-1:0] svc_wdata,
  output logic [mbd_pkg::DATA_W-1:0]      svc_rdata,
  output logic                            svc_done,
  output logic                            svc_busy,
  // priority chain
  input  wire logic                       chain_in,
  output logic                            chain_out,
  // memory bus
  mbd_bus_if.channel                      bus
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic                       req;
    logic                       hold;
    logic                       sel;
    logic                       grant_d;
    logic                       inh_d;
    logic                       start_d;
    logic [mbd_pkg::TW-1:0]     cnt;
    logic                       we;
    logic [mbd_pkg::ADDR_W-1:0] addr;
    logic [mbd_pkg::DATA_W-1:0] wdata;
    logic [mbd_pkg::DATA_W-1:0] dout;
    logic [mbd_pkg::DATA_W-1:0] rdata;
    logic                       data_oe;
    logic                       chain_out;
    logic                       done;
    logic                       busy;
  } mbd_chan_t;

  mbd_chan_t s;
  mbd_chan_t next_s;
  logic      grant_rise;
  logic      inh_end;
  logic      start_rise;
  logic      hold_now;
  logic      in_read;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s         = s;
    next_s.done    = 1'b0;
    next_s.grant_d = bus.grant_pulse;
    next_s.inh_d   = bus.inhibit_timing;
    next_s.start_d = svc_start;

    grant_rise = bus.grant_pulse & ~s.grant_d;
    inh_end    = s.inh_d & ~bus.inhibit_timing;
    start_rise = svc_start & ~s.start_d;
    in_read    = s.sel & ~s.we;

    // request frozen at the grant edge, so a late start cannot
    // flip the chain decision halfway through the pulse
    hold_now    = grant_rise ? s.req : s.hold;
    next_s.hold = hold_now;

    // position in the memory cycle, counted from the grant edge
    if (grant_rise) begin
      next_s.cnt = 6'h01;
    end else if (s.cnt != mbd_pkg::T_SAT) begin
      next_s.cnt = s.cnt + 6'h01;
    end

    // ----------------------------------------
    // service request
    // ----------------------------------------
    // a start while a transfer is pending or running is ignored
    if (start_rise && !s.req && !s.sel) begin
      next_s.req   = 1'b1;
      next_s.addr  = svc_addr;
      next_s.we    = svc_we;
      next_s.wdata = svc_wdata;
    end

    // ----------------------------------------
    // priority chain
    // ----------------------------------------
    // one register stage only: 20 ns per channel
    next_s.chain_out = bus.grant_pulse & chain_in & ~hold_now;

    if (bus.grant_pulse && chain_in && hold_now && !s.sel) begin
      next_s.sel     = 1'b1;
      next_s.req     = 1'b0;
      next_s.rdata   = '0;
      next_s.data_oe = s.we;
      next_s.dout    = s.wdata;
    end

    // ----------------------------------------
    // read capture and restore
    // ----------------------------------------
    // readout is single rail, so a zero bit never pulses:
    // accumulate ones over the whole window
    if (in_read && s.cnt >= mbd_pkg::T_RD_OPEN && s.cnt <= mbd_pkg::T_RD_CLOSE) begin
      next_s.rdata = s.rdata | bus.strobed_readout_lines[mbd_pkg::DATA_W-1:0];
    end

    if (in_read && s.cnt == mbd_pkg::T_RD_DRIVE) begin
      next_s.data_oe = 1'b1;
      next_s.dout    = s.rdata;
    end

    // ----------------------------------------
    // end of cycle
    // ----------------------------------------
    if (inh_end && s.sel) begin
      next_s.sel     = 1'b0;
      next_s.data_oe = 1'b0;
      next_s.done    = 1'b1;
    end

    next_s.busy = next_s.req | next_s.sel;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // address and write-select held for the whole select period
  assign bus.addr_o  = s.addr;
  assign bus.addr_oe = s.sel;
  assign bus.wsel_o  = s.we;
  assign bus.wsel_oe = s.sel;
  // only the low byte exists here; the parity bit is never driven
  assign bus.data_o  = s.dout;
  assign bus.data_oe = s.data_oe;
  assign bus.req_oe  = s.req;

  assign chain_out   = s.chain_out;
  assign svc_rdata   = s.rdata;
  assign svc_done    = s.done;
  assign svc_busy    = s.busy;

endmodule

`default_nettype wire

/* File: tb/mbd_bus_chk.sv */
// checker: cycle timing relations on the memory bus
`default_nettype none
module mbd_bus_chk (
  // clock and reset
  input wire logic                       mclk,
  input wire logic                       rst_n,
  // bus signals
  input wire logic                       grant_pulse,
  input wire logic                       inhibit_timing,
  input wire logic                       early_read_timing,
  input wire logic                       late_read_timing,
  input wire logic [mbd_pkg::DATA_W:0]   strobed_readout_lines,
  input wire logic [mbd_pkg::ADDR_W-1:0] addr_o,
  input wire logic                       addr_oe,
  input wire logic                       write_select,
  input wire logic [mbd_pkg::DATA_W-1:0] data_o,
  input wire logic                       data_oe,
  input wire logic [mbd_pkg::DATA_W:0]   mem_data_lines,
  input wire logic                       mem_request_line
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ---
  // cycle steps
  // ---
  sequence grant_rise;
    $rose(grant_pulse);
  endsequence
  sequence chan_cycle;
    grant_rise ##1 addr_oe;
  endsequence
  sequence read_restore;
    $rose(inhibit_timing) && !write_select && addr_oe;
  endsequence
  a_grant_width: assert property (grant_rise |-> ##11 grant_pulse ##1 !grant_pulse)
    else $error("grant pulse width wrong");
  a_inhibit_place: assert property (grant_rise |-> ##26 !inhibit_timing ##1 inhibit_timing[*8]
    ##1 inhibit_timing[*7] ##1 !inhibit_timing) else $error("inhibit window misplaced");
  a_early_read: assert property (grant_rise |-> ##1 early_read_timing[*8] ##1 !early_read_timing)
    else $error("early read window wrong");
  a_late_read: assert property (grant_rise |-> ##4 late_read_timing[*8] ##1 late_read_timing
    ##1 !late_read_timing) else $error("late read window wrong");
  a_readout_idle: assert property (grant_rise ##20 write_select |-> (strobed_readout_lines == '0)[*4])
    else $error("readout active on write");
  a_request_drop: assert property (chan_cycle |-> ##[0:23] !mem_request_line)
    else $error("request held after grant");
  a_addr_steady: assert property (addr_oe && $past(addr_oe) |-> $stable(addr_o) && $stable(write_select))
    else $error("address or write select moved");
  a_bus_release: assert property ($fell(inhibit_timing) |-> ##[0:9] !addr_oe && !data_oe && !write_select)
    else $error("bus not released after cycle");
  a_restore_data: assert property (read_restore |-> data_oe &&
    {1'b0, data_o} == ($past(strobed_readout_lines, 4) & 9'h0FF)) else $error("restore data wrong");
  a_data_hold: assert property (inhibit_timing && data_oe |=> data_oe && $stable(data_o))
    else $error("data lines moved in inhibit");
  a_parity_bit: assert property (inhibit_timing && data_oe |->
    mem_data_lines[mbd_pkg::DATA_W] == ^mem_data_lines[mbd_pkg::DATA_W-1:0]) else $error("parity bit not from data");
endmodule
`default_nettype wire

/* File: tb/tb_memory_bus_dma_cycle_port.sv */
// testbench: processor end and one dma channel joined by the memory bus
`default_nettype none
module tb_memory_bus_dma_cycle_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       mclk, rst_n, cpu_req, cpu_we, cpu_done, chain_in, chain_out;
  logic                       svc_start, svc_we, svc_done, svc_busy;
  logic [mbd_pkg::ADDR_W-1:0] cpu_addr, svc_addr, a;
  logic [mbd_pkg::DATA_W-1:0] cpu_wdata, cpu_rdata, svc_wdata, svc_rdata, d;
  logic [7:0]                 shadow [logic [13:0]];
  int                         fails, num_checks, cpu_dones, n;
  int unsigned                seed;
  mbd_bus_if bus ();
  mbd_device mbd_device_i (.mclk(mclk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_we(cpu_we),
    .cpu_wdata(cpu_wdata), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .bus(bus));
  mbd_channel mbd_channel_i (.mclk(mclk), .rst_n(rst_n), .svc_start(svc_start), .svc_addr(svc_addr),
    .svc_we(svc_we), .svc_wdata(svc_wdata), .svc_rdata(svc_rdata), .svc_done(svc_done), .svc_busy(svc_busy),
    .chain_in(chain_in), .chain_out(chain_out), .bus(bus));
  mbd_bus_chk mbd_bus_chk_i (.mclk(mclk), .rst_n(rst_n), .grant_pulse(bus.grant_pulse),
    .inhibit_timing(bus.inhibit_timing), .early_read_timing(bus.early_read_timing),
    .late_read_timing(bus.late_read_timing), .strobed_readout_lines(bus.strobed_readout_lines),
    .addr_o(bus.addr_o), .addr_oe(bus.addr_oe), .write_select(bus.write_select), .data_o(bus.data_o),
    .data_oe(bus.data_oe), .mem_data_lines(bus.mem_data_lines), .mem_request_line(bus.mem_request_line));
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (cpu_done === 1'b1) cpu_dones++;
  // ---
  // helpers
  // ---
  function automatic logic [7:0] exp_byte(input logic [13:0] ad);
    return shadow.exists(ad) ? shadow[ad] : 8'hXX;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp || $isunknown(got)) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait, done pulses are seen at the falling edge after they rise
  task automatic wait_done(input bit from_cpu);
    int k;
    k = 0;
    while (((from_cpu ? cpu_done : svc_done) !== 1'b1) && k < 300) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 300) begin
      chk("done within bound", 16'h0001, 16'h0000);
      wrap_up();
    end
  endtask
  task automatic dma(input logic we, input logic [13:0] ad, input logic [7:0] dv);
    svc_start = 1'b1;
    svc_we = we;
    svc_addr = ad;
    svc_wdata = dv;
    repeat (2) @(negedge mclk);
    svc_start = 1'b0;
    wait_done(1'b0);
    if (we) shadow[ad] = dv;
    else chk("svc_rdata", {8'h00, exp_byte(ad)}, {8'h00, svc_rdata});
  endtask
  task automatic cpu(input logic we, input logic [13:0] ad, input logic [7:0] dv);
    cpu_req = 1'b1;
    cpu_we = we;
    cpu_addr = ad;
    cpu_wdata = dv;
    @(negedge mclk);
    wait_done(1'b1);
    cpu_req = 1'b0;
    if (we) shadow[ad] = dv;
    else chk("cpu_rdata", {8'h00, exp_byte(ad)}, {8'h00, cpu_rdata});
  endtask
  // ---
  // main sequence
  // ---
  initial begin
    {mclk, rst_n, cpu_req, cpu_we, svc_start, svc_we} = 6'h00;
    {cpu_addr, svc_addr, cpu_wdata, svc_wdata} = '0;
    chain_in = 1'b1;
    {fails, num_checks, cpu_dones} = '0;
    seed = $urandom(32'hBF05);
    repeat (4) @(negedge mclk);
    chk("outputs in reset", 16'h0000, {12'h000, svc_busy, svc_done, chain_out, cpu_done});
    rst_n = 1'b1;
    @(negedge mclk);
    // extreme addresses and data, back to back
    dma(1'b1, 14'h0000, 8'hFF);
    dma(1'b1, 14'h3FFF, 8'h00);
    dma(1'b0, 14'h0000, 8'h00);
    dma(1'b0, 14'h3FFF, 8'h00);
    cpu(1'b1, 14'h1555, 8'hA5);
    dma(1'b0, 14'h1555, 8'h00);
    // processor and channel ask in the same cycle: the channel goes first
    n = cpu_dones;
    cpu_req = 1'b1;
    cpu_we = 1'b1;
    cpu_addr = 14'h2AAA;
    cpu_wdata = 8'h5A;
    shadow[14'h2AAA] = 8'h5A;
    dma(1'b0, 14'h1555, 8'h00);
    chk("cpu held behind dma", 16'(n), 16'(cpu_dones));
    wait_done(1'b1);
    @(negedge mclk);
    cpu_req = 1'b0;
    chk("dma ahead of cpu", 16'(n + 1), 16'(cpu_dones));
    repeat (50) @(negedge mclk);
    // chain held off: grants pass but the channel must never select
    chain_in = 1'b0;
    svc_start = 1'b1;
    svc_we = 1'b1;
    svc_addr = 14'h0123;
    svc_wdata = 8'h3C;
    repeat (2) @(negedge mclk);
    svc_start = 1'b0;
    repeat (120) @(negedge mclk);
    chk("busy while blocked", 16'h0001, {15'h0000, svc_busy});
    chk("no drive while blocked", 16'h0000, {14'h0000, bus.addr_oe, chain_out});
    chain_in = 1'b1;
    wait_done(1'b0);
    shadow[14'h0123] = 8'h3C;
    // unselected cycles read location zero and write zero back into it, so its old value is lost
    shadow.delete(14'h0000);
    dma(1'b0, 14'h0123, 8'h00);
    for (int i = 0; i < 30; i++) begin
      a = 14'($urandom);
      d = 8'($urandom);
      dma(1'b1, a, d);
      if ($urandom % 2) cpu(1'b0, a, 8'h00);
      else dma(1'b0, a, 8'h00);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
